// >>> hw/ltpwm_chan.sv
// Purpose: one pwm channel, log duty conversion with global dimming
// Assumes: shared period counter and tick from the top
// Notes: duty is reloaded only at the end of a period
`timescale 1ns/1ns
`default_nettype none
module ltpwm_chan (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // shared period timing
  input wire logic pwm_tick,
  input wire logic [ltpwm_pkg::PWM_BITS-1:0] pwm_count,
  // duty control
  input wire logic [7:0] duty_code,
  input wire logic [7:0] dim_code,
  input wire logic force_off,
  // output
  output logic pwm_out
);
  import ltpwm_pkg::*;

  logic [PWM_BITS:0] duty_reg, duty_next;
  logic pwm_next;
  logic period_end;

  // linear interpolation inside each halving stands in for the finer low-current curve
  function automatic logic [PWM_BITS:0] log_duty(input logic [7:0] code, input logic [7:0] dim);
    logic [8:0] atten;
    logic [4:0] oct;
    logic [5:0] rem;
    logic [12:0] mant;
    atten = 9'(DUTY_FULL - code) + 9'(dim);
    oct = 5'(atten / LOG_OCT_STEPS);
    rem = 6'(atten % LOG_OCT_STEPS);
    mant = DUTY_MAX - 13'((13'(rem) * LOG_SLOPE) >> 1);
    if (code == DUTY_OFF || dim == GDIM_OFF) begin
      log_duty = '0;
    end else begin
      log_duty = mant >> oct;
    end
  endfunction

  assign period_end = pwm_tick && (pwm_count == '1);

  always_comb begin
    duty_next = duty_reg;
    // reload at period end avoids a glitch in the running period
    if (period_end) begin
      duty_next = log_duty(duty_code, dim_code);
    end
    pwm_next = !force_off && ({1'b0, pwm_count} < duty_reg);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      duty_reg <= '0;
      pwm_out <= 1'b0;
    end else begin
      duty_reg <= duty_next;
      pwm_out <= pwm_next;
    end
  end

  property p_zero_off;
    @(posedge clk) disable iff (!nrst) duty_reg == '0 |=> !pwm_out;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero duty drove output");

  property p_full_on;
    @(posedge clk) disable iff (!nrst) (duty_reg == DUTY_MAX) && !force_off |=> pwm_out;
  endproperty
  a_full_on: assert property (p_full_on) else $error("full duty not on");

  property p_half_step;
    @(posedge clk) disable iff (!nrst)
      period_end && duty_code == 8'hDC && dim_code == 8'h00 |=> duty_reg == 13'h0800;
  endproperty
  a_half_step: assert property (p_half_step) else $error("35 steps did not halve duty");

  property p_dim_off;
    @(posedge clk) disable iff (!nrst) period_end && dim_code == GDIM_OFF |=> duty_reg == '0;
  endproperty
  a_dim_off: assert property (p_dim_off) else $error("dim code FF left output on");
endmodule // ltpwm_chan
`default_nettype wire

// >>> hw/ltpwm_pkg.sv
// Purpose: shared constants and types for the thermal LED PWM register bank
// Assumes: 10 MHz system clock, 8-bit register addresses on a two-wire serial bus
// Notes: offsets are byte addresses on the serial bus
package ltpwm_pkg;
  // clock and pwm timing
  localparam int CLK_HZ = 10_000_000;
  localparam int PWM_HZ = 280;
  localparam int PWM_BITS = 12;
  localparam int PWM_DIV = CLK_HZ / ((1 << PWM_BITS) * PWM_HZ);
  // serial address, arbitrary value
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;
  // register offsets
  localparam logic [7:0] REG_GDIM = 8'h04;
  localparam logic [7:0] REG_DUTY1 = 8'h05;
  localparam logic [7:0] REG_DUTY2 = 8'h06;
  localparam logic [7:0] REG_DUTY3 = 8'h07;
  localparam logic [7:0] REG_DIAG = 8'h19;
  localparam logic [7:0] REG_FGND = 8'h1C;
  localparam logic [7:0] REG_FVIN = 8'h1D;
  localparam logic [7:0] REG_CONFIG = 8'h1E;
  localparam logic [7:0] REG_SWRST = 8'h1F;
  localparam logic [7:0] REG_OFFSET = 8'h49;
  localparam logic [7:0] REG_TSHUT = 8'h4A;
  // fields
  localparam int DIAG_START_BIT = 5;
  localparam int FAULT_BITS = 6;
  localparam int TCODE_BITS = 5;
  localparam int OFF_BITS = 4;
  localparam int OFF_LED_LO = 4;
  localparam int OFF_DIODE_LO = 0;
  // reset values
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [TCODE_BITS-1:0] TSHUT_RESET = 5'h1C;
  // duty code meaning
  localparam logic [7:0] DUTY_OFF = 8'h00;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] GDIM_OFF = 8'hFF;
  // log curve: 35 steps of ~0.17 dB halve the duty, slope 117/2 per step
  localparam logic [8:0] LOG_OCT_STEPS = 9'h023;
  localparam logic [12:0] LOG_SLOPE = 13'h0075;
  localparam logic [12:0] DUTY_MAX = 13'h1000;
  // serial slave states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } ltpwm_i2c_state_t;
endpackage

// >>> hw/ltpwm_regs.sv
// Purpose: serial-bus register bank for a thermally derated three channel led pwm controller
// Assumes: temperature codes and diagnostic results come from logic on clk
// Notes: scl and sda are pins and pass a three flop filter
`timescale 1ns/1ns
`default_nettype none
// Function
// - duty code 00h gives 0% duty and FFh gives 100% duty.
// - in log mode each code step lowers brightness about 0.17 dB, finer below 300 uA.
// - channels two and three have their own duty registers with the same coding.
// - writing one to bit 5 of the diagnostic register starts a short/open diagnostic.
// - both fault registers use bits 5 to 0, one per sensed led.
// - a one in the ground fault register marks an led shorted to ground.
// - a one in the supply fault register marks an led shorted to supply or open.
// - the programmed offset is applied to measured junction temperature.
// - offset bits 7 to 4 are the led junction-ambient offset.
// - offset bits 3 to 0 are the silicon diode junction-ambient offset.
// - when sensed temperature reaches the shutdown code all channels go to 0%.
// - the shutdown code resets to 1Ch.
// - global dimming lowers all channels, 00h none, FEh about 43 dB, FFh off.
module ltpwm_regs #(
  parameter logic [6:0] DEV_ADDR = ltpwm_pkg::DEV_ADDR_DEFAULT,
  parameter int PWM_DIV = ltpwm_pkg::PWM_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // temperature
  input wire logic [ltpwm_pkg::TCODE_BITS-1:0] led_tj_code,
  input wire logic [ltpwm_pkg::TCODE_BITS-1:0] diode_tj_code,
  output logic [ltpwm_pkg::TCODE_BITS-1:0] led_ta_code,
  output logic [ltpwm_pkg::TCODE_BITS-1:0] diode_ta_code,
  output logic thermal_shutdown,
  // diagnostics
  output logic diag_start,
  input wire logic diag_done,
  input wire logic [ltpwm_pkg::FAULT_BITS-1:0] gnd_fault_in,
  input wire logic [ltpwm_pkg::FAULT_BITS-1:0] vin_fault_in,
  // configuration
  output logic [7:0] device_config,
  output logic [7:0] standby_control,
  // pwm
  output logic [2:0] pwm_out
);
  import ltpwm_pkg::*;

  // the prescaler is 16 bits wide, so larger dividers cannot be served
  if (PWM_DIV < 1 || PWM_DIV > 65536) begin : g_bad_div
    $error("PWM_DIV must be 1 to 65536");
  end

  // pin filter
  logic [2:0] scl_sync_reg, sda_sync_reg;
  logic scl_f_reg, scl_f_next, sda_f_reg, sda_f_next;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  // serial slave
  ltpwm_i2c_state_t state_reg, state_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next, rd_byte;
  logic rw_reg, rw_next, oe_next;
  logic wr_en;
  logic [7:0] wr_addr, wr_data;
  // register file
  logic [7:0] gdim_reg, gdim_next, diag_reg, diag_next, offset_reg, offset_next;
  logic [7:0] duty_reg [3];
  logic [7:0] duty_next [3];
  logic [FAULT_BITS-1:0] fgnd_reg, fgnd_next, fvin_reg, fvin_next;
  logic [TCODE_BITS-1:0] tshut_reg, tshut_next, led_ta_next, diode_ta_next;
  logic [7:0] config_next, standby_next;
  logic diag_start_next, shut_next;
  // pwm timing
  logic [15:0] presc_reg, presc_next;
  logic [PWM_BITS-1:0] cnt_reg, cnt_next;
  logic pwm_tick;

  function automatic logic [7:0] reg_read(input logic [7:0] a);
    case (a)
      REG_GDIM: reg_read = gdim_reg;
      REG_DUTY1: reg_read = duty_reg[0];
      REG_DUTY2: reg_read = duty_reg[1];
      REG_DUTY3: reg_read = duty_reg[2];
      REG_DIAG: reg_read = diag_reg;
      REG_FGND: reg_read = {2'h0, fgnd_reg};
      REG_FVIN: reg_read = {2'h0, fvin_reg};
      REG_CONFIG: reg_read = device_config;
      REG_SWRST: reg_read = standby_control;
      REG_OFFSET: reg_read = offset_reg;
      REG_TSHUT: reg_read = {3'h0, tshut_reg};
      default: reg_read = 8'h00;
    endcase
  endfunction

  function automatic logic [TCODE_BITS-1:0] sat_sub(input logic [TCODE_BITS-1:0] t,
                                                   input logic [OFF_BITS-1:0] off);
    sat_sub = (t > TCODE_BITS'(off)) ? TCODE_BITS'(t - TCODE_BITS'(off)) : '0;
  endfunction

  // a change counts once the second and third flops agree
  always_comb begin
    scl_f_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
    sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
    scl_rise = scl_f_next && !scl_f_reg;
    scl_fall = !scl_f_next && scl_f_reg;
    bus_start = scl_f_reg && scl_f_next && sda_f_reg && !sda_f_next;
    bus_stop = scl_f_reg && scl_f_next && !sda_f_reg && sda_f_next;
  end

  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    oe_next = sda_oe;
    wr_en = 1'b0;
    wr_addr = ptr_reg;
    wr_data = shift_reg;
    rd_byte = 8'h00;
    if (bus_stop) begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end else if (bus_start) begin
      state_next = ST_ADDR;
      bit_next = 4'h0;
      oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_f_reg};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == 4'h8) begin
            oe_next = 1'b1;
            if (state_reg == ST_ADDR) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                rw_next = shift_reg[0];
                state_next = ST_ADDR_ACK;
              end else begin
                oe_next = 1'b0;
                state_next = ST_IDLE;
              end
            end else if (state_reg == ST_REG) begin
              ptr_next = shift_reg;
              state_next = ST_REG_ACK;
            end else begin
              wr_en = 1'b1;
              state_next = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_next = 4'h0;
            if (rw_reg) begin
              rd_byte = reg_read(ptr_reg);
              shift_next = rd_byte;
              oe_next = !rd_byte[7];
              state_next = ST_RDATA;
            end else begin
              oe_next = 1'b0;
              state_next = ST_REG;
            end
          end
        end
        ST_REG_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            bit_next = 4'h0;
            if (state_reg == ST_WDATA_ACK) begin
              ptr_next = ptr_reg + 8'h01;
            end
            state_next = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_reg == 4'h8) begin
              oe_next = 1'b0;
              state_next = ST_RDATA_ACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = !shift_reg[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            rw_next = !sda_f_reg;
          end else if (scl_fall) begin
            if (rw_reg) begin
              ptr_next = ptr_reg + 8'h01;
              rd_byte = reg_read(ptr_reg + 8'h01);
              shift_next = rd_byte;
              oe_next = !rd_byte[7];
              bit_next = 4'h0;
              state_next = ST_RDATA;
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      state_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      scl_f_reg <= scl_f_next;
      sda_f_reg <= sda_f_next;
      state_reg <= state_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      sda_oe <= oe_next;
      sda_out <= 1'b0;
    end
  end

  always_comb begin
    gdim_next = gdim_reg;
    duty_next = duty_reg;
    diag_next = diag_reg;
    offset_next = offset_reg;
    tshut_next = tshut_reg;
    config_next = device_config;
    standby_next = standby_control;
    fgnd_next = fgnd_reg;
    fvin_next = fvin_reg;
    diag_start_next = 1'b0;
    if (diag_done) begin
      fgnd_next = gnd_fault_in;
      fvin_next = vin_fault_in;
      diag_next[DIAG_START_BIT] = 1'b0;
    end
    // a write in the done cycle lands after the clear, so a new request wins
    if (wr_en) begin
      case (wr_addr)
        REG_GDIM: gdim_next = wr_data;
        REG_DUTY1: duty_next[0] = wr_data;
        REG_DUTY2: duty_next[1] = wr_data;
        REG_DUTY3: duty_next[2] = wr_data;
        REG_DIAG: begin
          diag_next = wr_data;
          diag_start_next = wr_data[DIAG_START_BIT];
        end
        REG_CONFIG: config_next = wr_data;
        REG_SWRST: standby_next = wr_data;
        REG_OFFSET: offset_next = wr_data;
        REG_TSHUT: tshut_next = wr_data[TCODE_BITS-1:0];
        default: begin
        end // fault registers ignore writes
      endcase
    end
    shut_next = led_tj_code >= tshut_reg;
    led_ta_next = sat_sub(led_tj_code, offset_reg[OFF_LED_LO +: OFF_BITS]);
    diode_ta_next = sat_sub(diode_tj_code, offset_reg[OFF_DIODE_LO +: OFF_BITS]);
    presc_next = pwm_tick ? 16'h0000 : presc_reg + 16'h0001;
    cnt_next = pwm_tick ? cnt_reg + 1'b1 : cnt_reg;
  end

  assign pwm_tick = presc_reg == 16'(PWM_DIV - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gdim_reg <= REG8_RESET;
      duty_reg <= '{default: REG8_RESET};
      diag_reg <= REG8_RESET;
      offset_reg <= REG8_RESET;
      tshut_reg <= TSHUT_RESET;
      device_config <= REG8_RESET;
      standby_control <= REG8_RESET;
      fgnd_reg <= '0;
      fvin_reg <= '0;
      diag_start <= 1'b0;
      thermal_shutdown <= 1'b0;
      led_ta_code <= '0;
      diode_ta_code <= '0;
      presc_reg <= 16'h0000;
      cnt_reg <= '0;
    end else begin
      gdim_reg <= gdim_next;
      duty_reg <= duty_next;
      diag_reg <= diag_next;
      offset_reg <= offset_next;
      tshut_reg <= tshut_next;
      device_config <= config_next;
      standby_control <= standby_next;
      fgnd_reg <= fgnd_next;
      fvin_reg <= fvin_next;
      diag_start <= diag_start_next;
      thermal_shutdown <= shut_next;
      led_ta_code <= led_ta_next;
      diode_ta_code <= diode_ta_next;
      presc_reg <= presc_next;
      cnt_reg <= cnt_next;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_chan
    ltpwm_chan u_chan (
      .clk(clk),
      .nrst(nrst),
      .pwm_tick(pwm_tick),
      .pwm_count(cnt_reg),
      .duty_code(duty_reg[i]),
      .dim_code(gdim_reg),
      .force_off(thermal_shutdown),
      .pwm_out(pwm_out[i])
    );
  end

  property p_shut_set;
    @(posedge clk) disable iff (!nrst) led_tj_code >= tshut_reg |=> thermal_shutdown;
  endproperty
  a_shut_set: assert property (p_shut_set) else $error("shutdown not raised");

  property p_shut_off;
    @(posedge clk) disable iff (!nrst) thermal_shutdown |=> pwm_out == 3'h0;
  endproperty
  a_shut_off: assert property (p_shut_off) else $error("pwm active in shutdown");

  property p_tshut_reset;
    @(posedge clk) disable iff (!nrst) $past(!nrst) |-> tshut_reg == TSHUT_RESET;
  endproperty
  a_tshut_reset: assert property (p_tshut_reset) else $error("shutdown code reset wrong");

  property p_diag_start;
    @(posedge clk) disable iff (!nrst)
      wr_en && wr_addr == REG_DIAG && wr_data[DIAG_START_BIT] |=> diag_start ##1 !diag_start;
  endproperty
  a_diag_start: assert property (p_diag_start) else $error("diagnostic start not pulsed");

  property p_fault_ro;
    @(posedge clk) disable iff (!nrst) !diag_done |=> $stable(fgnd_reg) && $stable(fvin_reg);
  endproperty
  a_fault_ro: assert property (p_fault_ro) else $error("fault bits changed without diagnostic");

  property p_led_offset;
    @(posedge clk) disable iff (!nrst)
      led_tj_code > 5'h0F && offset_reg[7:4] == 4'h3 |=> led_ta_code == $past(led_tj_code) - 5'h03;
  endproperty
  a_led_offset: assert property (p_led_offset) else $error("led offset not applied");

  property p_diode_offset;
    @(posedge clk) disable iff (!nrst) diode_tj_code <= 5'(offset_reg[3:0]) |=> diode_ta_code == 5'h00;
  endproperty
  a_diode_offset: assert property (p_diode_offset) else $error("diode offset not saturated");
endmodule // ltpwm_regs
`default_nettype wire

// >>> sim/ltpwm_host.sv
// Purpose: behavioural two-wire bus master in place of the host controller
// Assumes: the bench resolves the open-drain data wire with a pull-up
// Notes: scl halves span 8 clk, twice what the pin filter needs
`timescale 1ns/1ns
`default_nettype none
module ltpwm_host #(
  parameter logic [6:0] ADDR = ltpwm_pkg::DEV_ADDR_DEFAULT
) (
  // clock
  input wire logic clk,
  // bus
  input wire logic sda,
  output var logic scl,
  output var logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (8) @(negedge clk);
  endtask
  // also serves as repeated start
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  // data is held 2 clk past the scl fall so the filtered edges never coincide
  task automatic clock_bit(output logic b);
    half();
    scl = 1'b1;
    half();
    b = sda;
    scl = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic sendb(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~d[i];
      clock_bit(b);
    end
    sda_low = 1'b0;
    clock_bit(b);
    ack = ~b;
  endtask
  task automatic recvb(input logic mack, output logic [7:0] d);
    logic b;
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b);
      d[i] = b;
    end
    sda_low = mack;
    clock_bit(b);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    start();
    sendb({ADDR, 1'b0}, k1);
    sendb(a, k2);
    sendb(d, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // combined protocol: pointer write, repeated start, one byte, master nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    sendb({ADDR, 1'b0}, k);
    sendb(a, k);
    start();
    sendb({ADDR, 1'b1}, k);
    recvb(1'b0, d);
    stop();
  endtask
endmodule // ltpwm_host
`default_nettype wire

// >>> sim/ltpwm_regs_test.sv
// Purpose: self-checking bench for the thermal led pwm register bank
// Assumes: PWM_DIV of 1 so one pwm period is 4096 clk
// Notes: expected duty counts come from the log curve worked out here
`timescale 1ns/1ns
`default_nettype none
module ltpwm_regs_test;
  import ltpwm_pkg::*;
  localparam int PERIOD = 4096;
  logic clk, nrst, host_scl, host_sda_low, sda_wire, sda_out, sda_oe;
  logic diag_start, diag_done, thermal_shutdown, ok;
  logic [4:0] led_tj_code, diode_tj_code, led_ta_code, diode_ta_code, t;
  logic [5:0] gnd_fault_in, vin_fault_in;
  logic [7:0] device_config, standby_control, d3, dim, off;
  logic [2:0] pwm_out;
  logic [15:0] seed, v;
  int err_count, n_compared, starts;
  // pull-up: the wire is low while either party pulls
  assign sda_wire = ~(sda_oe | host_sda_low);
  ltpwm_regs #(.DEV_ADDR(DEV_ADDR_DEFAULT), .PWM_DIV(1)) u_ltpwm_regs (.clk(clk), .nrst(nrst),
    .scl_in(host_scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .led_tj_code(led_tj_code), .diode_tj_code(diode_tj_code), .led_ta_code(led_ta_code),
    .diode_ta_code(diode_ta_code), .thermal_shutdown(thermal_shutdown), .diag_start(diag_start),
    .diag_done(diag_done), .gnd_fault_in(gnd_fault_in), .vin_fault_in(vin_fault_in),
    .device_config(device_config), .standby_control(standby_control), .pwm_out(pwm_out));
  ltpwm_host u_ltpwm_host (.clk(clk), .sda(sda_wire), .scl(host_scl), .sda_low(host_sda_low));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk) begin
    if (diag_start === 1'b1) starts++;
  end
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  function automatic int exp_duty(input int code, input int dm);
    int att;
    if (code == 0 || dm == 255) return 0;
    att = 255 - code + dm;
    return (4096 - ((att % 35) * 117) / 2) >> (att / 35);
  endfunction
  function automatic logic [4:0] sat(input logic [4:0] tj, input logic [3:0] o);
    return (tj > o) ? tj - 5'(o) : 5'h00;
  endfunction
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wrc(input logic [7:0] a, input logic [7:0] d);
    logic k;
    u_ltpwm_host.wr(a, d, k);
    chk("write_ack", 16'(k), 16'h0001);
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    u_ltpwm_host.rd(a, r);
    chk(name, 16'(r), 16'(exp));
  endtask
  task automatic pulse_done();
    diag_done = 1'b1;
    @(negedge clk);
    diag_done = 1'b0;
    @(negedge clk);
  endtask
  // waits past a reload, then counts high cycles over one whole period
  task automatic measure(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3,
    input logic [7:0] dm);
    int cnt [3];
    logic [7:0] c [3];
    c = '{c1, c2, c3};
    cnt = '{0, 0, 0};
    repeat (PERIOD + 100) @(negedge clk);
    repeat (PERIOD) begin
      @(negedge clk);
      for (int i = 0; i < 3; i++) cnt[i] += (pwm_out[i] === 1'b1) ? 1 : 0;
    end
    for (int i = 0; i < 3; i++) chk("pwm_high_count", 16'(cnt[i]), 16'(exp_duty(c[i], dm)));
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    results();
  end
  initial begin
    nrst = 1'b0;
    diag_done = 1'b0;
    gnd_fault_in = 6'h00;
    vin_fault_in = 6'h00;
    led_tj_code = 5'h00;
    diode_tj_code = 5'h00;
    seed = 16'h0011;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
    rdc("tshut_reset", REG_TSHUT, 8'h1C);
    rdc("duty1_reset", REG_DUTY1, 8'h00);
    chk("pwm_reset", 16'(pwm_out), 16'h0000);
    rdc("unmapped", 8'h30, 8'h00);
    u_ltpwm_host.start();
    u_ltpwm_host.sendb({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, ok);
    u_ltpwm_host.stop();
    chk("wrong_addr_ack", 16'(ok), 16'h0000);
    d3 = rnd() | 8'h01;
    wrc(REG_DUTY1, 8'hFF);
    wrc(REG_DUTY2, 8'h00);
    wrc(REG_DUTY3, d3);
    rdc("duty3", REG_DUTY3, d3);
    measure(8'hFF, 8'h00, d3, 8'h00);
    dim = rnd();
    wrc(REG_DUTY2, 8'hDC);
    wrc(REG_GDIM, dim);
    measure(8'hFF, 8'hDC, d3, dim);
    wrc(REG_GDIM, 8'hFF);
    measure(8'hFF, 8'hDC, d3, 8'hFF);
    wrc(REG_GDIM, 8'h00);
    led_tj_code = 5'h1B;
    repeat (PERIOD + 100) @(negedge clk);
    chk("below_shutdown", 16'({thermal_shutdown, pwm_out[0]}), 16'h0001);
    led_tj_code = 5'h1C;
    repeat (3) @(negedge clk);
    chk("at_shutdown", 16'({thermal_shutdown, pwm_out}), 16'h0008);
    v = {rnd(), rnd()};
    t = v[4:0] | 5'h01;
    wrc(REG_TSHUT, 8'(t));
    led_tj_code = t - 5'h01;
    repeat (3) @(negedge clk);
    chk("prog_below", 16'(thermal_shutdown), 16'h0000);
    led_tj_code = t;
    repeat (3) @(negedge clk);
    chk("prog_at", 16'({thermal_shutdown, pwm_out}), 16'h0008);
    for (int k = 0; k < 3; k++) begin
      off = rnd();
      if (k == 0) off[3:0] = off[7:4];
      // corner: led offset 3 above mid scale, diode offset saturating
      if (k == 2) off = 8'h3F;
      wrc(REG_OFFSET, off);
      rdc("offset", REG_OFFSET, off);
      for (int j = 0; j < 4; j++) begin
        v = {rnd(), rnd()};
        if (k == 2) v[4] = 1'b1;
        if (k == 2) v[12] = 1'b0;
        led_tj_code = v[4:0];
        diode_tj_code = v[12:8];
        repeat (2) @(negedge clk);
        chk("led_ta", 16'(led_ta_code), 16'(sat(v[4:0], off[7:4])));
        chk("diode_ta", 16'(diode_ta_code), 16'(sat(v[12:8], off[3:0])));
      end
    end
    led_tj_code = 5'h00;
    v = {rnd(), rnd()};
    gnd_fault_in = v[5:0];
    vin_fault_in = v[13:8];
    pulse_done();
    gnd_fault_in = ~v[5:0];
    vin_fault_in = ~v[13:8];
    rdc("gnd_fault", REG_FGND, {2'h0, v[5:0]});
    rdc("vin_fault", REG_FVIN, {2'h0, v[13:8]});
    wrc(REG_FGND, 8'hFF);
    wrc(REG_FVIN, 8'h00);
    rdc("gnd_fault_kept", REG_FGND, {2'h0, v[5:0]});
    rdc("vin_fault_kept", REG_FVIN, {2'h0, v[13:8]});
    starts = 0;
    wrc(REG_DIAG, 8'h20);
    chk("diag_pulses", 16'(starts), 16'h0001);
    rdc("diag_pending", REG_DIAG, 8'h20);
    pulse_done();
    rdc("diag_cleared", REG_DIAG, 8'h00);
    rdc("gnd_fault_new", REG_FGND, {2'h0, ~v[5:0]});
    v = {rnd(), rnd()};
    wrc(REG_CONFIG, v[7:0]);
    wrc(REG_SWRST, v[15:8]);
    chk("config_out", 16'(device_config), 16'(v[7:0]));
    chk("standby_out", 16'(standby_control), 16'(v[15:8]));
    rdc("config", REG_CONFIG, v[7:0]);
    // corner: two bytes written, then read back with a master ack between them
    u_ltpwm_host.start();
    u_ltpwm_host.sendb({DEV_ADDR_DEFAULT, 1'b0}, ok);
    u_ltpwm_host.sendb(REG_DUTY1, ok);
    u_ltpwm_host.sendb(8'h5A, ok);
    u_ltpwm_host.sendb(8'hA5, ok);
    u_ltpwm_host.stop();
    rdc("seq_write", REG_DUTY2, 8'hA5);
    u_ltpwm_host.start();
    u_ltpwm_host.sendb({DEV_ADDR_DEFAULT, 1'b0}, ok);
    u_ltpwm_host.sendb(REG_DUTY1, ok);
    u_ltpwm_host.start();
    u_ltpwm_host.sendb({DEV_ADDR_DEFAULT, 1'b1}, ok);
    u_ltpwm_host.recvb(1'b1, v[15:8]);
    u_ltpwm_host.recvb(1'b0, v[7:0]);
    u_ltpwm_host.stop();
    chk("seq_read", v, 16'h5AA5);
    chk("sda_out", 16'(sda_out), 16'h0000);
    // mid-run reset after the shutdown code was reprogrammed
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    chk("pwm_in_reset", 16'(pwm_out), 16'h0000);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
    chk("config_reset", 16'(device_config), 16'h0000);
    rdc("tshut_rereset", REG_TSHUT, 8'h1C);
    results();
  end
endmodule // ltpwm_regs_test
`default_nettype wire
